// ---- hdl/ppgc_pkg.sv ----
// Register map, field layout and load constants of the rectangular-wave compare shadow block
package ppgc_pkg;

   // Unit and register counts
   localparam int UNITS       = 2;
   localparam int NUM_TIM     = 6;
   localparam int NUM_CMP     = 5;
   localparam int TIMER_W     = 16;
   localparam int RATE_W      = 4;
   localparam int MDCY_W      = 3;
   localparam int ADDR_W      = 12;

   // Register indices inside one unit
   localparam logic [2:0] CYCLE_IDX   = 3'h0;
   localparam logic [2:0] LEAD_A_IDX  = 3'h1;
   localparam logic [2:0] TRAIL_A_IDX = 3'h2;
   localparam logic [2:0] LEAD_B_IDX  = 3'h3;
   localparam logic [2:0] TRAIL_B_IDX = 3'h4;
   localparam logic [2:0] PHASE_IDX   = 3'h5;

   // Byte addresses: control word, timing block, compare block
   localparam logic [ADDR_W-1:0] CTRL_OFF = 12'h000;
   localparam logic [ADDR_W-1:0] TIM_BASE = 12'h040;
   localparam logic [ADDR_W-1:0] CMP_BASE = 12'h080;
   localparam int BLK_LSB  = 6;
   localparam int UNIT_BIT = 5;
   localparam int IDX_MSB  = 4;
   localparam int IDX_LSB  = 2;

   // Control word layout
   localparam int CTRL_LDSEL_LSB = 0;
   localparam int CTRL_UPDEN_LSB = 2;
   localparam int CTRL_ILK_BIT   = 4;
   localparam int CTRL_MDCY_LSB  = 8;
   localparam int MDCY_STRIDE    = 4;
   localparam logic [31:0] CTRL_MASK  = 32'h0077_771f;
   localparam logic [31:0] RST_VALUE  = 32'h0000_0000;

   // Field positions inside timing and compare words
   localparam int EDGE_PLAIN_LSB = 0;
   localparam int EDGE_TRAIL_LSB = 4;
   localparam int PHASE_LSB      = 1;
   localparam int RATE_LSB       = 0;

   // Writable bits of each timing word; compare copies keep the same layout
   function automatic logic [31:0] word_mask(input logic [2:0] idx);
      case (idx)
         CYCLE_IDX, LEAD_A_IDX, LEAD_B_IDX: word_mask = 32'h0000_ffff;
         TRAIL_A_IDX, TRAIL_B_IDX:          word_mask = 32'h000f_ffff;
         PHASE_IDX:                         word_mask = 32'h0001_fffe;
         default:                           word_mask = 32'h0000_0000;
      endcase
   endfunction : word_mask

   // Valid modulation rate bits per modulation cycle setting
   function automatic logic [RATE_W-1:0] rate_mask(input logic [MDCY_W-1:0] cy);
      case (cy)
         3'h0:    rate_mask = 4'h0;
         3'h1:    rate_mask = 4'h8;
         3'h2:    rate_mask = 4'hc;
         3'h3:    rate_mask = 4'he;
         3'h4:    rate_mask = 4'hf;
         default: rate_mask = 4'h0;
      endcase
   endfunction : rate_mask

endpackage : ppgc_pkg

// ---- hdl/ppgc_shadow.sv ----
// APB register file with double-buffered compare registers for two timer units
//
// How it works
// - Unit-0 phase-shift timing word holds a 16-bit read/write value in bits 16..1.
// - Phase-shift value reaches its output only in interlocked mode, zero otherwise.
// - Cycle compare is read-only, 16 bits in bits 15..0, the unit period.
// - In interlocked mode unit 1 does not use its own cycle compare.
// - Compare words are shadow copies; bus writes to them are refused.
// - Leading-edge compares expose read-only 16 bits in 15..0 from their timing word.
// - Trailing-edge compares hold timing in 19..4 and rate in 3..0, loaded together.
// - Load select 0: a timing write lands in its compare in the same write.
// - Load select 1: copy only at the unit update point with update enable set.
// - Modulation cycle setting selects which rate bits are valid, none to all four.
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps

module ppgc_shadow #(
   parameter int TIMER_W = ppgc_pkg::TIMER_W
) (
   input  wire logic                         CLK_IN,
   input  wire logic                         RST_N_IN,
   input  wire logic                         PSEL_IN,
   input  wire logic                         PENABLE_IN,
   input  wire logic                         PWRITE_IN,
   input  wire logic [ppgc_pkg::ADDR_W-1:0]  PADDR_IN,
   input  wire logic [31:0]                  PWDATA_IN,
   output logic      [31:0]                  PRDATA_OUT,
   output logic                              PREADY_OUT,
   output logic                              PSLVERR_OUT,
   input  wire logic [1:0]                   UPDATE_POINT_IN,
   output logic      [2*TIMER_W-1:0]         CYCLE_CMP_OUT,
   output logic      [2*TIMER_W-1:0]         LEAD_A_CMP_OUT,
   output logic      [2*TIMER_W-1:0]         TRAIL_A_CMP_OUT,
   output logic      [2*TIMER_W-1:0]         LEAD_B_CMP_OUT,
   output logic      [2*TIMER_W-1:0]         TRAIL_B_CMP_OUT,
   output logic      [7:0]                   RATE_A_OUT,
   output logic      [7:0]                   RATE_B_OUT,
   output logic      [TIMER_W-1:0]           PHASE_SHIFT_OUT,
   output logic                              INTERLOCK_OUT,
   output logic                              UNIT1_PERIOD_EN_OUT
);

   // Field layout is fixed by the word map, so only the documented width is served
   if (TIMER_W != 16)
   begin : g_width_check
      $error("ppgc_shadow: TIMER_W must be 16");
   end

   localparam int UN = ppgc_pkg::UNITS;
   localparam int NT = ppgc_pkg::NUM_TIM;
   localparam int NC = ppgc_pkg::NUM_CMP;

   logic [31:0] ctrl_q;
   logic [31:0] tim_q  [UN][NT];
   logic [31:0] cmp_q  [UN][NC];
   logic [31:0] rdata_q;
   logic        ack_q;
   logic        err_q;

   // Address decode
   wire         blk_tim   = PADDR_IN[ppgc_pkg::ADDR_W-1:ppgc_pkg::BLK_LSB]
                            == ppgc_pkg::TIM_BASE[ppgc_pkg::ADDR_W-1:ppgc_pkg::BLK_LSB];
   wire         blk_cmp   = PADDR_IN[ppgc_pkg::ADDR_W-1:ppgc_pkg::BLK_LSB]
                            == ppgc_pkg::CMP_BASE[ppgc_pkg::ADDR_W-1:ppgc_pkg::BLK_LSB];
   wire         aligned   = PADDR_IN[1:0] == 2'h0;
   wire         sel_unit  = PADDR_IN[ppgc_pkg::UNIT_BIT];
   wire [2:0]   sel_idx   = PADDR_IN[ppgc_pkg::IDX_MSB:ppgc_pkg::IDX_LSB];
   wire         ctrl_hit  = PADDR_IN == ppgc_pkg::CTRL_OFF;
   // Unit 1 has no phase-shift word
   wire         phase_gap = sel_unit && (sel_idx == ppgc_pkg::PHASE_IDX);
   wire         tim_hit   = blk_tim && aligned && (32'(sel_idx) < NT) && !phase_gap;
   wire         cmp_hit   = blk_cmp && aligned && (32'(sel_idx) < NC);

   // Control fields
   wire [1:0]   ld_sel    = ctrl_q[ppgc_pkg::CTRL_LDSEL_LSB +: 2];
   wire [1:0]   upd_en    = ctrl_q[ppgc_pkg::CTRL_UPDEN_LSB +: 2];
   wire         interlock = ctrl_q[ppgc_pkg::CTRL_ILK_BIT];

   // APB phases: one wait state, so read data is taken from a flip-flop
   wire         acc_first = PSEL_IN && PENABLE_IN && !ack_q;
   wire         acc_done  = PSEL_IN && PENABLE_IN && ack_q;
   // Compare words are read-only and refuse bus writes
   wire         acc_err   = !(ctrl_hit || tim_hit || cmp_hit) || (PWRITE_IN && cmp_hit);
   wire         wr_ok     = acc_done && PWRITE_IN && !err_q;
   wire         ctrl_wr   = wr_ok && ctrl_hit;

   // Read selection; reserved bits are already zero in storage
   wire [31:0]  rd_mux    = ctrl_hit ? ctrl_q :
                            tim_hit  ? tim_q[sel_unit][sel_idx] :
                            cmp_hit  ? cmp_q[sel_unit][sel_idx] : ppgc_pkg::RST_VALUE;
   wire [31:0]  ctrl_d    = ctrl_wr ? (PWDATA_IN & ppgc_pkg::CTRL_MASK) : ctrl_q;

   // Bus handshake and registered answer
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         ack_q   <= 1'b0;
         err_q   <= 1'b0;
         rdata_q <= ppgc_pkg::RST_VALUE;
      end
      else
      begin
         ack_q   <= acc_first;
         err_q   <= acc_first && acc_err;
         rdata_q <= (acc_first && !acc_err) ? rd_mux : ppgc_pkg::RST_VALUE;
      end
   end

   // Control word: load select, update enable, interlock, modulation cycles
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
         ctrl_q <= ppgc_pkg::RST_VALUE;
      else
         ctrl_q <= ctrl_d;
   end

   assign PREADY_OUT  = ack_q;
   assign PSLVERR_OUT = ack_q && err_q;
   assign PRDATA_OUT  = rdata_q;

   // Per unit, per register storage and shadow load
   for (genvar u = 0; u < UN; u++)
   begin : g_unit
      // Update point only counts when buffered mode and update enable are both set
      wire buf_load = ld_sel[u] && upd_en[u] && UPDATE_POINT_IN[u];
      for (genvar m = 0; m < NT; m++)
      begin : g_reg
         localparam logic [2:0]  IDX  = 3'(m);
         localparam logic [31:0] MASK = ((u == 1) && (m == 5)) ? 32'h0000_0000 :
                                        ppgc_pkg::word_mask(IDX);
         wire        tim_wr = wr_ok && tim_hit && (sel_unit == 1'(u)) && (sel_idx == IDX);
         // Masking drops writes to reserved positions
         wire [31:0] tim_d  = tim_wr ? (PWDATA_IN & MASK) : tim_q[u][m];

         always_ff @(posedge CLK_IN or negedge RST_N_IN)
         begin
            if (!RST_N_IN)
               tim_q[u][m] <= ppgc_pkg::RST_VALUE;
            else
               tim_q[u][m] <= tim_d;
         end

         if (m < NC)
         begin : g_cmp
            // Direct mode copies the written value; buffered mode waits for the update point.
            // A write in buffered mode never disturbs the copy, even at the update point.
            wire [31:0] cmp_d = (!ld_sel[u] && tim_wr) ? (PWDATA_IN & MASK) :
                                buf_load ? tim_q[u][m] : cmp_q[u][m];

            always_ff @(posedge CLK_IN or negedge RST_N_IN)
            begin
               if (!RST_N_IN)
                  cmp_q[u][m] <= ppgc_pkg::RST_VALUE;
               else
                  cmp_q[u][m] <= cmp_d;
            end
         end
      end

      // Compare values toward the match detectors
      wire [2:0] cy_a = ctrl_q[ppgc_pkg::CTRL_MDCY_LSB + ppgc_pkg::MDCY_STRIDE*(2*u)
                               +: ppgc_pkg::MDCY_W];
      wire [2:0] cy_b = ctrl_q[ppgc_pkg::CTRL_MDCY_LSB + ppgc_pkg::MDCY_STRIDE*(2*u+1)
                               +: ppgc_pkg::MDCY_W];
      assign CYCLE_CMP_OUT[u*TIMER_W +: TIMER_W]   =
         cmp_q[u][ppgc_pkg::CYCLE_IDX][ppgc_pkg::EDGE_PLAIN_LSB +: TIMER_W];
      assign LEAD_A_CMP_OUT[u*TIMER_W +: TIMER_W]  =
         cmp_q[u][ppgc_pkg::LEAD_A_IDX][ppgc_pkg::EDGE_PLAIN_LSB +: TIMER_W];
      assign LEAD_B_CMP_OUT[u*TIMER_W +: TIMER_W]  =
         cmp_q[u][ppgc_pkg::LEAD_B_IDX][ppgc_pkg::EDGE_PLAIN_LSB +: TIMER_W];
      assign TRAIL_A_CMP_OUT[u*TIMER_W +: TIMER_W] =
         cmp_q[u][ppgc_pkg::TRAIL_A_IDX][ppgc_pkg::EDGE_TRAIL_LSB +: TIMER_W];
      assign TRAIL_B_CMP_OUT[u*TIMER_W +: TIMER_W] =
         cmp_q[u][ppgc_pkg::TRAIL_B_IDX][ppgc_pkg::EDGE_TRAIL_LSB +: TIMER_W];
      // Invalid rate bits are forced low so the modulator never sees them
      assign RATE_A_OUT[u*4 +: 4] = ppgc_pkg::rate_mask(cy_a) &
         cmp_q[u][ppgc_pkg::TRAIL_A_IDX][ppgc_pkg::RATE_LSB +: 4];
      assign RATE_B_OUT[u*4 +: 4] = ppgc_pkg::rate_mask(cy_b) &
         cmp_q[u][ppgc_pkg::TRAIL_B_IDX][ppgc_pkg::RATE_LSB +: 4];
   end

   // Phase shift only matters when the units are interlocked
   assign PHASE_SHIFT_OUT     = interlock ?
      tim_q[0][ppgc_pkg::PHASE_IDX][ppgc_pkg::PHASE_LSB +: TIMER_W] : 16'h0000;
   assign INTERLOCK_OUT       = interlock;
   // Unit 1 follows unit 0 in interlocked mode
   assign UNIT1_PERIOD_EN_OUT = !interlock;

   // Checks on the register behaviour
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);

   wire tim0_lead_wr = wr_ok && tim_hit && !sel_unit && (sel_idx == ppgc_pkg::LEAD_A_IDX);
   wire cmp_wr_try   = acc_first && PWRITE_IN && cmp_hit;

   a_direct_load_copy: assert property (
      tim0_lead_wr && !ld_sel[0] |=>
         LEAD_A_CMP_OUT[TIMER_W-1:0] == $past(PWDATA_IN[TIMER_W-1:0]))
      else $error("Direct mode did not copy the timing write");

   a_buffer_hold_value: assert property (
      ld_sel[0] && !(upd_en[0] && UPDATE_POINT_IN[0]) |=>
         $stable(TRAIL_A_CMP_OUT[TIMER_W-1:0]) && $stable(CYCLE_CMP_OUT[TIMER_W-1:0]))
      else $error("Buffered compare changed without an update point");

   a_buffer_load_copy: assert property (
      ld_sel[1] && upd_en[1] && UPDATE_POINT_IN[1] |=>
         CYCLE_CMP_OUT[2*TIMER_W-1:TIMER_W] == $past(tim_q[1][0][TIMER_W-1:0]))
      else $error("Update point did not load the compare copy");

   a_phase_ignored_off: assert property (
      !INTERLOCK_OUT |-> PHASE_SHIFT_OUT == 16'h0000)
      else $error("Phase shift visible outside interlocked mode");

   a_unit1_period_off: assert property (
      INTERLOCK_OUT |-> !UNIT1_PERIOD_EN_OUT)
      else $error("Unit 1 period enabled while interlocked");

   a_compare_write_refused: assert property (
      cmp_wr_try |=> PREADY_OUT && PSLVERR_OUT ##1 $stable(LEAD_A_CMP_OUT))
      else $error("Write to a compare word was not refused");

   a_rate_bits_masked: assert property (
      ctrl_q[ppgc_pkg::CTRL_MDCY_LSB +: 3] == 3'h1 |-> RATE_A_OUT[2:0] == 3'h0)
      else $error("Invalid modulation rate bits leaked");

   a_reserved_read_zero: assert property (
      acc_first && !PWRITE_IN && cmp_hit && (sel_idx == ppgc_pkg::TRAIL_A_IDX) |=>
         PRDATA_OUT[31:20] == 12'h000)
      else $error("Reserved compare bits read nonzero");

   a_apb_one_wait: assert property (
      PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
      else $error("APB answer not after exactly one wait state");

   // Further checks, copies first, field by field. Each check on a timing write looks one cycle after the
   // write's ready edge, when the compare flop has taken the new word.
   wire tim0_wr   = wr_ok && tim_hit && !sel_unit;
   wire tim1_wr   = wr_ok && tim_hit && sel_unit;
   wire [2:0] cy0 = ctrl_q[ppgc_pkg::CTRL_MDCY_LSB +: ppgc_pkg::MDCY_W];

   a_cycle_b_direct: assert property (
      tim1_wr && (sel_idx == ppgc_pkg::CYCLE_IDX) && !ld_sel[1] |=>
         CYCLE_CMP_OUT[2*TIMER_W-1:TIMER_W] == $past(PWDATA_IN[TIMER_W-1:0]))
      else $error("Unit 1 direct cycle copy wrong");

   a_trail_direct_copy: assert property (
      tim0_wr && (sel_idx == ppgc_pkg::TRAIL_A_IDX) && !ld_sel[0] |=>
         TRAIL_A_CMP_OUT[TIMER_W-1:0] == $past(PWDATA_IN[19:4]))
      else $error("Trailing timing not copied from bits 19..4");

   a_trail_rate_copy: assert property (
      tim0_wr && (sel_idx == ppgc_pkg::TRAIL_A_IDX) && !ld_sel[0] |=>
         cmp_q[0][ppgc_pkg::TRAIL_A_IDX][3:0] == $past(PWDATA_IN[3:0]))
      else $error("Rate not loaded together with trailing timing");

   a_lead_b_copy: assert property (
      tim0_wr && (sel_idx == ppgc_pkg::LEAD_B_IDX) && !ld_sel[0] |=>
         LEAD_B_CMP_OUT[TIMER_W-1:0] == $past(PWDATA_IN[TIMER_W-1:0]))
      else $error("Second leading compare not copied");

   a_buffered_write_hold: assert property (
      tim0_wr && ld_sel[0] && !(upd_en[0] && UPDATE_POINT_IN[0]) |=>
         $stable(CYCLE_CMP_OUT[TIMER_W-1:0]) && $stable(LEAD_A_CMP_OUT[TIMER_W-1:0]))
      else $error("Buffered write reached a compare early");

   a_buffer_load_unit0: assert property (
      ld_sel[0] && upd_en[0] && UPDATE_POINT_IN[0] |=>
         CYCLE_CMP_OUT[TIMER_W-1:0] == $past(tim_q[0][0][TIMER_W-1:0]))
      else $error("Unit 0 update point did not load");

   a_phase_follows_on: assert property (
      INTERLOCK_OUT |->
         PHASE_SHIFT_OUT == tim_q[0][ppgc_pkg::PHASE_IDX][ppgc_pkg::PHASE_LSB +: TIMER_W])
      else $error("Phase shift not shown while interlocked");

   a_unit1_period_on: assert property (
      !INTERLOCK_OUT |-> UNIT1_PERIOD_EN_OUT)
      else $error("Unit 1 period disabled while standalone");

   a_error_read_zero: assert property (
      acc_first && acc_err |=> PRDATA_OUT == ppgc_pkg::RST_VALUE)
      else $error("Refused transfer returned data");

   a_error_no_ctrl: assert property (
      acc_done && err_q |=> $stable(ctrl_q))
      else $error("Refused transfer changed the control word");

   a_ready_one_cycle: assert property (
      PREADY_OUT |=> !PREADY_OUT)
      else $error("Ready held for more than one cycle");

   a_error_with_ready: assert property (
      PSLVERR_OUT |-> PREADY_OUT)
      else $error("Slave error without ready");

   a_ctrl_reserved_zero: assert property (
      (ctrl_q & ~ppgc_pkg::CTRL_MASK) == ppgc_pkg::RST_VALUE)
      else $error("Reserved control bits set");

   a_phase_reserved_zero: assert property (
      (tim_q[0][ppgc_pkg::PHASE_IDX] & ~ppgc_pkg::word_mask(ppgc_pkg::PHASE_IDX))
         == ppgc_pkg::RST_VALUE)
      else $error("Reserved phase word bits set");

   a_rate_all_valid: assert property (
      cy0 == 3'h4 |-> RATE_A_OUT[3:0] == cmp_q[0][ppgc_pkg::TRAIL_A_IDX][3:0])
      else $error("Full rate setting masked bits");

   a_rate_none_valid: assert property (
      cy0 == 3'h0 |-> RATE_A_OUT[3:0] == 4'h0)
      else $error("Rate bits shown with no valid bits");

   // Main scenarios that the bench is expected to reach
   c_unit1_buffer: cover property (ld_sel[1] && upd_en[1] && UPDATE_POINT_IN[1]);
   c_direct_load:  cover property (tim0_lead_wr && !ld_sel[0]);
   c_buffer_load:  cover property (ld_sel[0] && upd_en[0] && UPDATE_POINT_IN[0]);
   c_phase_active: cover property (INTERLOCK_OUT && PHASE_SHIFT_OUT != 16'h0000);
   c_slave_error:  cover property (PSLVERR_OUT);

endmodule : ppgc_shadow

// ---- dv/ppgc_testbench.sv ----
// Self-checking APB testbench for the rectangular-wave compare shadow block
`timescale 1ns/1ps

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end

module testbench;
   logic        CLK_IN, RST_N_IN, PSEL_IN, PENABLE_IN, PWRITE_IN;
   logic [11:0] PADDR_IN;
   logic [31:0] PWDATA_IN, PRDATA_OUT;
   logic        PREADY_OUT, PSLVERR_OUT, INTERLOCK_OUT, UNIT1_PERIOD_EN_OUT;
   logic [1:0]  UPDATE_POINT_IN;
   logic [31:0] CYCLE_CMP_OUT, LEAD_A_CMP_OUT, TRAIL_A_CMP_OUT, LEAD_B_CMP_OUT, TRAIL_B_CMP_OUT;
   logic [7:0]  RATE_A_OUT, RATE_B_OUT;
   logic [15:0] PHASE_SHIFT_OUT;
   int          mismatches = 0;
   int          n_tests = 0;
   logic [31:0] rd, msk [6];
   logic [3:0]  vm [5];
   logic        err;

   ppgc_shadow u_ppgc_shadow (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
      .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
      .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
      .PSLVERR_OUT(PSLVERR_OUT), .UPDATE_POINT_IN(UPDATE_POINT_IN),
      .CYCLE_CMP_OUT(CYCLE_CMP_OUT), .LEAD_A_CMP_OUT(LEAD_A_CMP_OUT),
      .TRAIL_A_CMP_OUT(TRAIL_A_CMP_OUT), .LEAD_B_CMP_OUT(LEAD_B_CMP_OUT),
      .TRAIL_B_CMP_OUT(TRAIL_B_CMP_OUT), .RATE_A_OUT(RATE_A_OUT), .RATE_B_OUT(RATE_B_OUT),
      .PHASE_SHIFT_OUT(PHASE_SHIFT_OUT), .INTERLOCK_OUT(INTERLOCK_OUT),
      .UNIT1_PERIOD_EN_OUT(UNIT1_PERIOD_EN_OUT));

   // 25 MHz clock
   initial CLK_IN = 1'b0;
   always #20 CLK_IN = ~CLK_IN;

   // Byte addresses of timing and compare words
   function automatic logic [11:0] tim(input int u, input int m);
      tim = 12'h040 + 12'(32 * u + 4 * m);
   endfunction : tim
   function automatic logic [11:0] cmp(input int u, input int m);
      cmp = 12'h080 + 12'(32 * u + 4 * m);
   endfunction : cmp
   // Distinct pattern per word; low rate nibble all ones so masks show
   function automatic logic [31:0] pat(input int u, input int m);
      pat = 32'hfedc_ba9f ^ (32'(u * 8 + m) << 8);
   endfunction : pat

   // One APB transfer; request held until PREADY is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdata, output logic e);
      @(posedge CLK_IN);
      PSEL_IN <= 1'b1; PENABLE_IN <= 1'b0; PWRITE_IN <= wr; PADDR_IN <= a; PWDATA_IN <= wd;
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      // Only the watchdog ends a wait that never sees ready
      do @(posedge CLK_IN); while (PREADY_OUT !== 1'b1);
      rdata = PRDATA_OUT;
      e = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
      `CHK(e, 1'b0)
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(e, 1'b0)
      `CHK(r, exp)
   endtask : rdchk

   // One-cycle update point pulse, outputs judged half a cycle after it is taken
   task automatic pulse0(input logic [1:0] p);
      @(posedge CLK_IN);
      UPDATE_POINT_IN <= p;
      @(posedge CLK_IN);
      UPDATE_POINT_IN <= 2'h0;
      @(negedge CLK_IN);
   endtask : pulse0

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // Watchdog: whole sequence needs well under 2000 cycles
   initial
   begin
      repeat (20000) @(posedge CLK_IN);
      mismatches++;
      print_verdict();
   end

   initial
   begin
      msk = '{32'h0000_ffff, 32'h0000_ffff, 32'h000f_ffff, 32'h0000_ffff, 32'h000f_ffff, 32'h0001_fffe};
      vm = '{4'h0, 4'h8, 4'hc, 4'he, 4'hf};
      RST_N_IN = 1'b0; PSEL_IN = 1'b0; PENABLE_IN = 1'b0; PWRITE_IN = 1'b0;
      PADDR_IN = 12'h000; PWDATA_IN = 32'h0; UPDATE_POINT_IN = 2'h0;
      repeat (16) @(posedge CLK_IN);
      RST_N_IN <= 1'b1;
      // Compare words come out of reset at zero
      for (int u = 0; u < 2; u++) for (int m = 0; m < 5; m++) rdchk(cmp(u, m), 32'h0);
      `CHK(UNIT1_PERIOD_EN_OUT, 1'b1)
      // Direct load: timing write lands in compare, reserved bits dropped
      for (int u = 0; u < 2; u++) for (int m = 0; m < 5; m++) wr(tim(u, m), pat(u, m));
      for (int u = 0; u < 2; u++) for (int m = 0; m < 5; m++)
      begin
         rdchk(tim(u, m), pat(u, m) & msk[m]);
         rdchk(cmp(u, m), pat(u, m) & msk[m]);
      end
      `CHK(CYCLE_CMP_OUT, {16'(pat(1, 0)), 16'(pat(0, 0))})
      `CHK(LEAD_A_CMP_OUT, {16'(pat(1, 1)), 16'(pat(0, 1))})
      `CHK(LEAD_B_CMP_OUT, {16'(pat(1, 3)), 16'(pat(0, 3))})
      `CHK(TRAIL_A_CMP_OUT, {16'(pat(1, 2) >> 4), 16'(pat(0, 2) >> 4)})
      `CHK(TRAIL_B_CMP_OUT, {16'(pat(1, 4) >> 4), 16'(pat(0, 4) >> 4)})
      // Compare words refuse direct writes and keep their value
      apb(1'b1, cmp(0, 1), 32'h0, rd, err);
      `CHK(err, 1'b1)
      rdchk(cmp(0, 1), pat(0, 1) & msk[1]);
      apb(1'b0, 12'hffc, 32'h0, rd, err);
      `CHK({err, rd}, {1'b1, 32'h0})
      apb(1'b0, tim(1, 5), 32'h0, rd, err);
      `CHK(err, 1'b1)
      // Phase shift word only counts when interlocked
      wr(tim(0, 5), 32'hffff_ffff);
      rdchk(tim(0, 5), 32'h0001_fffe);
      `CHK(PHASE_SHIFT_OUT, 16'h0)
      wr(12'h000, 32'h0000_0010);
      rdchk(12'h000, 32'h0000_0010);
      `CHK({PHASE_SHIFT_OUT, INTERLOCK_OUT, UNIT1_PERIOD_EN_OUT}, {16'hffff, 2'b10})
      // Modulation cycle settings 0 to 4 on all four trailing compares
      for (int c = 0; c < 5; c++)
      begin
         wr(12'h000, 32'h10 | (32'(c) * 32'h0001_1100) | (32'(c) << 20));
         // Control word lands at the ready edge; judge it half a cycle on
         @(negedge CLK_IN);
         `CHK(RATE_A_OUT, {4'(pat(1, 2)) & vm[c], 4'(pat(0, 2)) & vm[c]})
         `CHK(RATE_B_OUT, {4'(pat(1, 4)) & vm[c], 4'(pat(0, 4)) & vm[c]})
      end
      // Buffered load on unit 0: needs update point and update enable
      wr(12'h000, 32'h0000_0001);
      wr(tim(0, 0), 32'h0000_1234);
      wr(tim(1, 0), 32'h0000_4321);
      rdchk(cmp(0, 0), pat(0, 0) & msk[0]);
      rdchk(cmp(1, 0), 32'h0000_4321);
      pulse0(2'h1);
      `CHK(CYCLE_CMP_OUT[15:0], 16'(pat(0, 0)))
      wr(12'h000, 32'h0000_0005);
      pulse0(2'h1);
      `CHK(CYCLE_CMP_OUT, 32'h4321_1234)
      // Buffered load on unit 1 through its own update point
      wr(12'h000, 32'h0000_000a);
      wr(tim(1, 0), 32'h0000_5678);
      rdchk(cmp(1, 0), 32'h0000_4321);
      pulse0(2'h2);
      `CHK(CYCLE_CMP_OUT, 32'h5678_1234)
      print_verdict();
   end
endmodule : testbench
